// [rtl/ulms_consts.vh]
// Purpose: Constants for the UART line and modem status block
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes: Register values sit in the low bits, upper bits read as zero
`ifndef ULMS_CONSTS_VH
`define ULMS_CONSTS_VH

// Register byte offsets
`define ULMS_OFF_RX_DATA 8'h00
`define ULMS_OFF_LINE_STATUS 8'h04
`define ULMS_OFF_MODEM_STATUS 8'h08
`define ULMS_OFF_MODEM_CONTROL 8'h0c
`define ULMS_OFF_CONTROL 8'h10
`define ULMS_OFF_INT_STATUS 8'h14
`define ULMS_OFF_INT_MASK 8'h18

// Line status fields
`define ULMS_LS_DATA_READY 0
`define ULMS_LS_OVERRUN 1
`define ULMS_LS_PARITY 2
`define ULMS_LS_FRAMING 3

// Modem control fields
`define ULMS_MC_LOOPBACK 4
`define ULMS_MC_WIDTH 5

// Control fields
`define ULMS_CTL_FIFO_EN 0

// Interrupt status fields
`define ULMS_IS_RX_DATA 0
`define ULMS_IS_LINE_ERR 1
`define ULMS_IS_MODEM 2
`define ULMS_IS_WIDTH 3

// Reset values
`define ULMS_RST_EFC 8'h00
`define ULMS_RST_MC 5'h00
`define ULMS_RST_MASK 3'h0
`define ULMS_RST_SYNC 4'hf

`endif

// [rtl/ulms_top.v]
// Purpose: Line status (low half) and modem status of one UART channel
// Assumes: Receiver datapath on clk_in; modem inputs asynchronous pins
// Notes: APB slave with one wait state; reads have side effects
// Operation
// - A framing error is flagged for the character at the FIFO top.
// - A parity error is flagged for the character at the FIFO top.
// - Overrun is set when a character completes while the FIFO is full.
// - An overrunning character is dropped so stored data stays intact.
// - Data ready reads one while any received character is held.
// - Modem status shares its address with a write-only register.
// - Writes at that address go to extra feature control only.
// - Reading modem status clears the change flags that the read returned.
// - Bit 7 is inverted carrier detect, or control bit 3 in loopback.
// - Bit 6 is inverted ring indicator, or control bit 2 in loopback.
// - Bit 5 is inverted DSR, or control bit 0 in loopback.
// - Bit 4 is inverted CTS, or control bit 1 in loopback.
// - Carrier, DSR and CTS change flags set on either edge.
// - The ring change flag sets only when the ring pin goes 0 to 1.
// - Any set change flag raises the modem status interrupt.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`include "ulms_consts.vh"

module ulms_top #(
   parameter RX_DEPTH = 16,
   parameter RX_AW = 4
)(
   input wire clk_in,
   input wire resetn_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire [31:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   input wire rx_done_in,
   input wire [7:0] rx_data_in,
   input wire rx_frame_err_in,
   input wire rx_par_err_in,
   input wire cd_n_in,
   input wire ri_n_in,
   input wire dsr_n_in,
   input wire cts_n_in,
   output wire irq_out,
   output wire msi_out,
   output wire [7:0] efc_out,
   output wire [3:0] mcr_out,
   output wire loop_out
);

   // Sticky flag update where a new event beats a clear
   function [7:0] ulms_sticky;
      input [7:0] cur;
      input [7:0] set;
      input [7:0] clr;
      begin
         ulms_sticky = (cur & ~clr) | set;
      end
   endfunction

   reg [31:0] prdata_r;
   reg pready_r;
   reg pslverr_r;
   reg irq_r;
   reg msi_r;
   reg [7:0] efc_r;
   reg [`ULMS_MC_WIDTH-1:0] mcr_r;
   reg fifo_en_r;
   reg [`ULMS_IS_WIDTH-1:0] ist_r;
   reg [`ULMS_IS_WIDTH-1:0] mask_r;
   reg [3:0] ms1_r;
   reg [3:0] ms2_r;
   reg [3:0] prev_r;
   reg [3:0] delta_r;
   reg ovr_r;
   reg [9:0] mem [0:RX_DEPTH-1];
   reg [RX_AW-1:0] wp_r;
   reg [RX_AW-1:0] rp_r;
   reg [RX_AW:0] cnt_r;

   wire capture = psel_in & penable_in & ~pready_r;
   wire done = psel_in & penable_in & pready_r;
   wire wr_done = done & pwrite_in;
   wire rd_done = done & ~pwrite_in;

   // Modem inputs in order cd, ri, dsr, cts
   wire [3:0] pins_n = {cd_n_in, ri_n_in, dsr_n_in, cts_n_in};
   wire loop = mcr_r[`ULMS_MC_LOOPBACK];
   wire [3:0] cur = loop ? {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1]}
                         : ~ms2_r;
   wire [3:0] change;
   assign change[3] = cur[3] ^ prev_r[3];
   assign change[2] = prev_r[2] & ~cur[2];
   assign change[1] = cur[1] ^ prev_r[1];
   assign change[0] = cur[0] ^ prev_r[0];
   wire [7:0] modem_status = {cur, delta_r};

   // Receive store; capacity is one when the FIFO is disabled
   wire [RX_AW:0] depth = RX_DEPTH[RX_AW:0];
   wire empty = (cnt_r == {(RX_AW+1){1'b0}});
   wire full = fifo_en_r ? (cnt_r == depth) : ~empty;
   wire push = rx_done_in & ~full;
   wire ovr_set = rx_done_in & full;
   wire [9:0] top = mem[rp_r];
   wire top_fe = ~empty & top[8];
   wire top_pe = ~empty & top[9];
   wire [7:0] line_status = {4'h0, top_fe, top_pe, ovr_r, ~empty};

   wire [RX_AW-1:0] one_a = {{(RX_AW-1){1'b0}}, 1'b1};
   wire [RX_AW:0] one_c = {{RX_AW{1'b0}}, 1'b1};

   // Address match shared by every side-effect decode
   function ulms_hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         ulms_hit = (addr == off);
      end
   endfunction

   // Completed accesses that change state; a read that only
   // reaches the wait state has no side effect yet
   wire rd_rx_done = rd_done & ulms_hit(paddr_in, `ULMS_OFF_RX_DATA);
   wire rd_ls_done = rd_done & ulms_hit(paddr_in, `ULMS_OFF_LINE_STATUS);
   wire rd_ms_done = rd_done & ulms_hit(paddr_in, `ULMS_OFF_MODEM_STATUS);
   wire wr_ctl_done = wr_done & ulms_hit(paddr_in, `ULMS_OFF_CONTROL);
   wire wr_is_done = wr_done & ulms_hit(paddr_in, `ULMS_OFF_INT_STATUS);
   wire pop = rd_rx_done & ~empty;
   wire fifo_en_wr = wr_ctl_done;
   wire flush = fifo_en_wr & (pwdata_in[`ULMS_CTL_FIFO_EN] != fifo_en_r);

   // Read data mux and address decode
   reg [31:0] rd_mux;
   reg mapped;
   always @*
   begin
      rd_mux = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr_in)
         `ULMS_OFF_RX_DATA:
         begin
            rd_mux = {24'h000000, top[7:0]};
         end
         `ULMS_OFF_LINE_STATUS:
         begin
            rd_mux = {24'h000000, line_status};
         end
         // Write side of this address is extra feature control
         `ULMS_OFF_MODEM_STATUS:
         begin
            rd_mux = {24'h000000, modem_status};
         end
         `ULMS_OFF_MODEM_CONTROL:
         begin
            rd_mux = {27'h0000000, mcr_r};
         end
         `ULMS_OFF_CONTROL:
         begin
            rd_mux = {31'h00000000, fifo_en_r};
         end
         `ULMS_OFF_INT_STATUS:
         begin
            rd_mux = {29'h00000000, ist_r};
         end
         `ULMS_OFF_INT_MASK:
         begin
            rd_mux = {29'h00000000, mask_r};
         end
         default:
         begin
            mapped = 1'b0;
         end
      endcase
   end

   // Only flags seen by the captured read are cleared, so a change
   // arriving during the wait state survives to the next read
   wire [3:0] delta_clr = rd_ms_done ? prdata_r[3:0] : 4'h0;
   wire ovr_clr = rd_ls_done & prdata_r[`ULMS_LS_OVERRUN];
   // Line error covers overrun and any errored character stored
   wire ist_modem_set = |change;
   wire ist_line_set = ovr_set | (push & (rx_frame_err_in | rx_par_err_in));
   wire ist_rx_set = push;
   wire [`ULMS_IS_WIDTH-1:0] ist_set = {ist_modem_set, ist_line_set,
      ist_rx_set};
   wire [`ULMS_IS_WIDTH-1:0] ist_clr = wr_is_done
      ? pwdata_in[`ULMS_IS_WIDTH-1:0] : {`ULMS_IS_WIDTH{1'b0}};
   wire [7:0] delta_nxt = ulms_sticky({4'h0, delta_r}, {4'h0, change},
                                      {4'h0, delta_clr});
   wire [7:0] ovr_nxt = ulms_sticky({7'h00, ovr_r}, {7'h00, ovr_set},
                                    {7'h00, ovr_clr});
   wire [7:0] ist_nxt = ulms_sticky({5'h00, ist_r}, {5'h00, ist_set},
                                    {5'h00, ist_clr});

   // APB slave: one wait state, data latched in the wait state
   always @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= capture;
         pslverr_r <= capture & ~mapped;
         // Latched in the wait state so the clear sees what was shown
         if (capture & ~pwrite_in)
         begin
            prdata_r <= rd_mux;
         end
      end
   end

   // Software registers
   always @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         efc_r <= `ULMS_RST_EFC;
         mcr_r <= `ULMS_RST_MC;
         fifo_en_r <= 1'b0;
         mask_r <= `ULMS_RST_MASK;
      end
      else if (wr_done)
      begin
         case (paddr_in)
            `ULMS_OFF_MODEM_STATUS:
            begin
               efc_r <= pwdata_in[7:0];
            end
            `ULMS_OFF_MODEM_CONTROL:
            begin
               mcr_r <= pwdata_in[`ULMS_MC_WIDTH-1:0];
            end
            `ULMS_OFF_CONTROL:
            begin
               fifo_en_r <= pwdata_in[`ULMS_CTL_FIFO_EN];
            end
            `ULMS_OFF_INT_MASK:
            begin
               mask_r <= pwdata_in[`ULMS_IS_WIDTH-1:0];
            end
            // Read-only, unmapped and interrupt status offsets leave these registers unchanged
            default:
            begin
               efc_r <= efc_r;
            end
         endcase
      end
   end

   // Modem inputs: two-stage synchroniser before edge detection
   always @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ms1_r <= `ULMS_RST_SYNC;
         ms2_r <= `ULMS_RST_SYNC;
      end
      else
      begin
         ms1_r <= pins_n;
         ms2_r <= ms1_r;
      end
   end

   // Edge detection on the substituted value; only the second
   // synchroniser stage feeds it, so a metastable first stage
   // never reaches the change flags
   always @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         prev_r <= 4'h0;
         delta_r <= 4'h0;
         msi_r <= 1'b0;
      end
      else
      begin
         prev_r <= cur;
         delta_r <= delta_nxt[3:0];
         msi_r <= |delta_r;
      end
   end

   // Receive store and overrun
   always @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         wp_r <= {RX_AW{1'b0}};
         rp_r <= {RX_AW{1'b0}};
         cnt_r <= {(RX_AW+1){1'b0}};
         ovr_r <= 1'b0;
      end
      else
      begin
         ovr_r <= ovr_nxt[0];
         if (flush)
         begin
            wp_r <= {RX_AW{1'b0}};
            rp_r <= {RX_AW{1'b0}};
            cnt_r <= {(RX_AW+1){1'b0}};
         end
         else
         begin
            if (push)
            begin
               wp_r <= wp_r + one_a;
            end
            if (pop)
            begin
               rp_r <= rp_r + one_a;
            end
            // Push and pop together leave the count unchanged
            if (push & ~pop)
            begin
               cnt_r <= cnt_r + one_c;
            end
            else if (pop & ~push)
            begin
               cnt_r <= cnt_r - one_c;
            end
         end
      end
   end

   // Storage has no reset; error bits are used only when counted, but RX data reads return the top entry even when empty
   always @(posedge clk_in)
   begin
      if (push & ~flush)
      begin
         mem[wp_r] <= {rx_par_err_in, rx_frame_err_in, rx_data_in};
      end
   end

   // Interrupt status and output
   always @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ist_r <= {`ULMS_IS_WIDTH{1'b0}};
      end
      else
      begin
         ist_r <= ist_nxt[`ULMS_IS_WIDTH-1:0];
      end
   end

   // Registered so the pin never glitches; costs one cycle of lag
   always @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= |(ist_r & mask_r);
      end
   end

   assign prdata_out = prdata_r;
   assign pready_out = pready_r;
   assign pslverr_out = pslverr_r;
   assign irq_out = irq_r;
   assign msi_out = msi_r;
   assign efc_out = efc_r;
   assign mcr_out = mcr_r[3:0];
   assign loop_out = mcr_r[`ULMS_MC_LOOPBACK];

endmodule

// [test/ulms_monitor.sv]
// Purpose: Port checker for the line and modem status block
// Assumes: APB answer one cycle after penable, pins quiet between steps
// Notes: Pin checks wait six quiet cycles to cover the synchroniser
module ulms_monitor(
   input wire clk_in,
   input wire resetn_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [31:0] prdata_out,
   input wire pready_out,
   input wire pslverr_out,
   input wire cd_n_in,
   input wire ri_n_in,
   input wire dsr_n_in,
   input wire cts_n_in,
   input wire msi_out,
   input wire [7:0] efc_out,
   input wire [3:0] mcr_out,
   input wire loop_out
);
   wire rd_ms = pready_out && !pwrite_in && paddr_in == 8'h08;
   wire [3:0] pin = {cd_n_in, ri_n_in, dsr_n_in, cts_n_in};
   wire [2:0] oth = {cd_n_in, dsr_n_in, cts_n_in};
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   property p_rdy;
      $rose(penable_in) && psel_in |=> pready_out;
   endproperty
   a_rdy: assert property (p_rdy) else $error("late ready");
   property p_err;
      pready_out |->
         pslverr_out == (paddr_in > 8'h18 || paddr_in[1:0] != 2'h0);
   endproperty
   a_err: assert property (p_err) else $error("bad slverr");
   property p_msi;
      rd_ms |-> msi_out == (|prdata_out[3:0]);
   endproperty
   a_msi: assert property (p_msi) else $error("msi mismatch");
   property p_pins;
      (!loop_out && $stable(pin))[*6] ##0 rd_ms |-> prdata_out[7:4] == ~pin;
   endproperty
   a_pins: assert property (p_pins) else $error("pin bits");
   property p_loop;
      (loop_out && $stable(mcr_out))[*6] ##0 rd_ms |->
         prdata_out[7:4] == {mcr_out[3], mcr_out[2], mcr_out[0], mcr_out[1]};
   endproperty
   a_loop: assert property (p_loop) else $error("loop bits");
   property p_efc;
      logic [7:0] d;
      (pready_out && pwrite_in && paddr_in == 8'h08, d = pwdata_in[7:0])
         |=> efc_out == d;
   endproperty
   a_efc: assert property (p_efc) else $error("efc not stored");
   property p_cts;
      $changed(cts_n_in) && !loop_out |-> ##[1:5] msi_out;
   endproperty
   a_cts: assert property (p_cts) else $error("cts no flag");
   // Ring falling edge alone must stay silent
   property p_ri;
      !msi_out && $fell(ri_n_in) && $stable(oth) && !loop_out
         |-> (!msi_out)[*5];
   endproperty
   a_ri: assert property (p_ri) else $error("ring fall flagged");
   c_loop: cover property (rd_ms && loop_out);
   c_err: cover property (pready_out && pslverr_out);
   c_msi: cover property ($rose(msi_out));
endmodule

bind ulms_top ulms_monitor u_mon(.clk_in, .resetn_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
   .pready_out, .pslverr_out, .cd_n_in, .ri_n_in, .dsr_n_in, .cts_n_in,
   .msi_out, .efc_out, .mcr_out, .loop_out);

// [test/ulms_modem.sv]
// Purpose: Modem side model driving the four status pins
// Assumes: Pins idle high, changed just after a clock edge
// Notes: Lag argument mimics a slow or prompt modem
module ulms_modem(
   input wire logic clk_in,
   output logic [3:0] pins_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pins_n_out = 4'hf;
   task automatic drive(input logic [3:0] v, input int lag);
      repeat (lag) @(posedge clk_in);
      pins_n_out <= v;
   endtask
endmodule

// [test/ulms_top_tb.sv]
// Purpose: Self-checking bench for the line and modem status block
// Assumes: One wait state APB, FIFO off holds one character
// Notes: Pin order is cd, ri, dsr, cts
module ulms_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, resetn_in, psel_in, penable_in, pwrite_in, err;
   logic [7:0] paddr_in, rx_data_in, efc_out;
   logic [31:0] pwdata_in, prdata_out, q;
   logic pready_out, pslverr_out, rx_done_in, rx_frame_err_in;
   logic rx_par_err_in, cd_n_in, ri_n_in, dsr_n_in, cts_n_in;
   logic irq_out, msi_out, loop_out;
   logic [3:0] mcr_out, pins;
   int mismatches, n_checks;
   ulms_top dut(.*);
   ulms_modem u_modem(.clk_in, .pins_n_out(pins));
   assign {cd_n_in, ri_n_in, dsr_n_in, cts_n_in} = pins;
   initial
   begin
      clk_in = 1'h0;
      forever #10 clk_in = ~clk_in;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Leading edge wait keeps back-to-back calls from double driving
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge clk_in);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'h2, w, a, d};
      @(posedge clk_in);
      penable_in <= 1'h1;
      n = 0;
      @(posedge clk_in);
      while (pready_out !== 1'h1 && n < 20)
      begin
         @(posedge clk_in);
         n++;
      end
      if (n == 20)
      begin
         mismatches++;
         print_verdict;
      end
      q = prdata_out;
      err = pslverr_out;
      {psel_in, penable_in} <= 2'h0;
   endtask
   task automatic rx(input logic [9:0] v);
      @(posedge clk_in);
      {rx_par_err_in, rx_frame_err_in, rx_data_in} <= v;
      rx_done_in <= 1'h1;
      @(posedge clk_in);
      rx_done_in <= 1'h0;
   endtask
   task automatic t_regs;
      apb(1'h0, 8'h04, 32'h0);
      chk(q, 32'h0);
      apb(1'h0, 8'h1c, 32'h0);
      chk({q[30:0], err}, 32'h1);
      apb(1'h1, 8'h08, 32'h5a);
      cyc(1);
      chk({24'h0, efc_out}, 32'h5a);
      apb(1'h0, 8'h08, 32'h0);
      chk(q, 32'h0);
   endtask
   task automatic t_modem;
      logic [3:0] v [5] = '{4'he, 4'ha, 4'he, 4'h4, 4'hf};
      logic [7:0] e [5] = '{8'h11, 8'h50, 8'h14, 8'hba, 8'h0b};
      for (int i = 0; i < 5; i++)
      begin
         u_modem.drive(v[i], 3);
         cyc(6);
         chk({31'h0, msi_out}, {31'h0, |e[i][3:0]});
         apb(1'h0, 8'h08, 32'h0);
         chk(q, {24'h0, e[i]});
      end
      apb(1'h0, 8'h08, 32'h0);
      chk(q, 32'h0);
   endtask
   task automatic t_loop;
      apb(1'h1, 8'h0c, 32'h1a);
      cyc(4);
      apb(1'h0, 8'h08, 32'h0);
      apb(1'h0, 8'h08, 32'h0);
      chk(q, 32'h90);
      chk({27'h0, loop_out, mcr_out}, 32'h1a);
      apb(1'h1, 8'h0c, 32'h0);
      cyc(4);
      apb(1'h0, 8'h08, 32'h0);
      chk(q, 32'h09);
   endtask
   task automatic t_rx;
      apb(1'h1, 8'h14, 32'h7);
      apb(1'h1, 8'h18, 32'h1);
      rx(10'h03c);
      cyc(2);
      chk({31'h0, irq_out}, 32'h1);
      apb(1'h1, 8'h18, 32'h0);
      cyc(2);
      chk({31'h0, irq_out}, 32'h0);
      apb(1'h0, 8'h04, 32'h0);
      chk(q, 32'h1);
      apb(1'h0, 8'h00, 32'h0);
      chk(q, 32'h3c);
      rx(10'h1a5);
      rx(10'h0ff);
      apb(1'h0, 8'h04, 32'h0);
      chk(q, 32'h0b);
      apb(1'h0, 8'h00, 32'h0);
      chk(q, 32'ha5);
      apb(1'h0, 8'h04, 32'h0);
      chk(q, 32'h0);
      apb(1'h1, 8'h10, 32'h1);
      rx(10'h011);
      rx(10'h222);
      apb(1'h0, 8'h04, 32'h0);
      chk(q, 32'h1);
      apb(1'h0, 8'h00, 32'h0);
      apb(1'h0, 8'h04, 32'h0);
      chk(q, 32'h5);
      apb(1'h1, 8'h14, 32'h7);
      apb(1'h1, 8'h18, 32'h7);
      cyc(2);
      chk({31'h0, irq_out}, 32'h0);
   endtask
   initial
   begin
      {psel_in, penable_in, pwrite_in, rx_done_in, err} = 5'h0;
      {paddr_in, pwdata_in, rx_data_in} = 48'h0;
      {rx_frame_err_in, rx_par_err_in, resetn_in} = 3'h0;
      cyc(5);
      resetn_in <= 1'h1;
      t_regs;
      t_modem;
      t_loop;
      t_rx;
      print_verdict;
   end
endmodule
